// ==== hdl/pcd_pkg.sv ====
package pcd_pkg;
    // Port widths
    localparam int PCD_PORTC_W = 8;
    localparam int PCD_PORTD_W = 3;
    // Port-C bit positions
    localparam int PCD_OSC_OUT_BIT = 7;
    localparam int PCD_OSC_IN_BIT  = 6;
    localparam int PCD_TDI_BIT     = 5;
    localparam int PCD_TDO_BIT     = 4;
    localparam int PCD_TMS_BIT     = 3;
    localparam int PCD_TCK_BIT     = 2;
    localparam int PCD_SDA_BIT     = 1;
    localparam int PCD_SCL_BIT     = 0;
    // Port-D upper pins, indexed 0..2 for bits 5..7
    localparam int PCD_PD5_IDX = 0;
    localparam int PCD_PD6_IDX = 1;
    localparam int PCD_PD7_IDX = 2;
    // Pin-change source numbering
    localparam int PCD_PCS_C_LO = 16;
    localparam int PCD_PCS_D_LO = 29;
    // Reset values of the synchroniser stages
    localparam logic [7:0] PCD_RST_C = 8'h00;
    localparam logic [2:0] PCD_RST_D = 3'h0;
endpackage : pcd_pkg

// ==== hdl/pcd_mux.sv ====
// Functional notes
// - Port-C pins feed pin-change sources 23..16
// - Port-D pins 7..5 feed sources 31..29
// - Async oscillator with external clock select overrides port-C bit 7
// - Async timer overrides port-C bit 6
// - Test port takes port-C bits 5..2
// - Bit 4 drives test data while shifting
// - Two-wire takes port-C bits 1, 0
// - Two-wire pins keep digital inputs enabled
// - Port-D bit 6 feeds timer1 capture
// - Global pull-up disable kills every pull-up except on the test port pins, which stay pulled up
module pcd_mux (
    // Clock and reset
    input  wire  logic                            clk,
    input  wire  logic                            reset,
    // Port-C registers and pads
    input  wire  logic [pcd_pkg::PCD_PORTC_W-1:0] portc_data,
    input  wire  logic [pcd_pkg::PCD_PORTC_W-1:0] portc_direction,
    input  wire  logic [pcd_pkg::PCD_PORTC_W-1:0] portc_pin_in,
    output logic       [pcd_pkg::PCD_PORTC_W-1:0] portc_pin_out,
    output logic       [pcd_pkg::PCD_PORTC_W-1:0] portc_pin_oe,
    output logic       [pcd_pkg::PCD_PORTC_W-1:0] portc_pullup_on,
    output logic       [pcd_pkg::PCD_PORTC_W-1:0] portc_input_enable,
    output logic       [pcd_pkg::PCD_PORTC_W-1:0] portc_pin_sync,
    // Port-D bits 7..5 registers and pads
    input  wire  logic [pcd_pkg::PCD_PORTD_W-1:0] portd_data,
    input  wire  logic                            portd_bit7_direction,
    input  wire  logic                            portd_bit6_direction,
    input  wire  logic                            portd_bit5_direction,
    input  wire  logic [pcd_pkg::PCD_PORTD_W-1:0] portd_pin_in,
    output logic       [pcd_pkg::PCD_PORTD_W-1:0] portd_pin_out,
    output logic       [pcd_pkg::PCD_PORTD_W-1:0] portd_pin_oe,
    output logic       [pcd_pkg::PCD_PORTD_W-1:0] portd_pullup_on,
    // Global and group controls
    input  wire  logic                            global_pullup_disable,
    input  wire  logic                            pin_change_group_enable_c,
    input  wire  logic                            pin_change_group_enable_d,
    input  wire  logic [pcd_pkg::PCD_PORTC_W-1:0] pin_change_mask_c,
    input  wire  logic [pcd_pkg::PCD_PORTD_W-1:0] pin_change_mask_d,
    // Timer oscillator
    input  wire  logic                            async_timer_clock_select,
    input  wire  logic                            external_clock_select,
    output logic                                  timer_osc_in_pin,
    output logic                                  timer_osc_out_active,
    // Test access port
    input  wire  logic                            test_port_enable,
    input  wire  logic                            tap_shift_instruction_state,
    input  wire  logic                            tap_shift_data_state,
    input  wire  logic                            tap_data_out,
    output logic                                  tap_data_in,
    output logic                                  tap_mode_select,
    output logic                                  tap_clock,
    // Two-wire interface
    input  wire  logic                            two_wire_enable,
    input  wire  logic                            two_wire_data_out,
    input  wire  logic                            two_wire_clock_out,
    output logic                                  two_wire_data_in,
    output logic                                  two_wire_clock_in,
    // Timers
    input  wire  logic                            timer2_compare_a_output,
    input  wire  logic                            timer2_compare_b_output,
    input  wire  logic                            timer1_compare_a_output,
    input  wire  logic                            timer2_compare_a_enable,
    input  wire  logic                            timer2_compare_b_enable,
    input  wire  logic                            timer1_compare_a_enable,
    output logic                                  timer1_capture_input,
    // Pin-change sources 31..16 (bits 28..24 unused, read zero)
    output logic       [31:16]                    pin_change_source
);
    import pcd_pkg::*;

    // Override controls per port-C pin
    logic [PCD_PORTC_W-1:0] pullup_override_enable, pullup_override_value;
    logic [PCD_PORTC_W-1:0] direction_override_enable, direction_override_value;
    logic [PCD_PORTC_W-1:0] output_override_enable, output_override_value;
    logic [PCD_PORTC_W-1:0] input_enable_override_enable, input_enable_override_value;
    logic [PCD_PORTC_W-1:0] c_meta, c_sync, next_c_meta, next_c_sync;
    logic [PCD_PORTD_W-1:0] d_meta, d_sync, next_d_meta, next_d_sync;
    logic [PCD_PORTD_W-1:0] d_direction, d_ovr_en, d_ovr_val;
    logic                   osc_ext, tap_shift;

    assign osc_ext   = async_timer_clock_select & external_clock_select;
    assign tap_shift = tap_shift_instruction_state | tap_shift_data_state;

    // Override table for port C; a zero enable leaves the pin to its registers
    always_comb begin
        pullup_override_enable       = '0;
        pullup_override_value        = '0;
        direction_override_enable    = '0;
        direction_override_value     = '0;
        output_override_enable       = '0;
        output_override_value        = '0;
        input_enable_override_enable = pin_change_mask_c & {PCD_PORTC_W{pin_change_group_enable_c}};
        input_enable_override_value  = input_enable_override_enable;
        // Oscillator output pin: float and input only
        pullup_override_enable[PCD_OSC_OUT_BIT]    = osc_ext;
        direction_override_enable[PCD_OSC_OUT_BIT] = osc_ext;
        if (osc_ext) begin
            input_enable_override_enable[PCD_OSC_OUT_BIT] = 1'b1;
            input_enable_override_value[PCD_OSC_OUT_BIT]  = async_timer_clock_select;
        end
        // Oscillator input pin
        pullup_override_enable[PCD_OSC_IN_BIT]    = async_timer_clock_select;
        direction_override_enable[PCD_OSC_IN_BIT] = async_timer_clock_select;
        if (async_timer_clock_select) begin
            input_enable_override_enable[PCD_OSC_IN_BIT] = 1'b1;
            input_enable_override_value[PCD_OSC_IN_BIT]  =
                external_clock_select | async_timer_clock_select;
        end
        // Test port pins: pull-up on, input enabled
        if (test_port_enable) begin
            for (int i = PCD_TCK_BIT; i <= PCD_TDI_BIT; i++) begin
                pullup_override_enable[i]       = 1'b1;
                pullup_override_value[i]        = 1'b1;
                direction_override_enable[i]    = 1'b1;
                input_enable_override_enable[i] = 1'b1;
                input_enable_override_value[i]  = 1'b1;
            end
            direction_override_value[PCD_TDO_BIT] = tap_shift;
            output_override_enable[PCD_TDO_BIT]   = 1'b1;
            output_override_value[PCD_TDO_BIT]    = tap_data_out;
        end
        // Two-wire pins: direction input, output from interface
        // Global disable still gates the pull-up, so an external bus keeper wins
        if (two_wire_enable) begin
            for (int i = PCD_SCL_BIT; i <= PCD_SDA_BIT; i++) begin
                pullup_override_enable[i]    = 1'b1;
                pullup_override_value[i]     = portc_data[i] & ~global_pullup_disable;
                direction_override_enable[i] = 1'b1;
                output_override_enable[i]    = 1'b1;
            end
            output_override_value[PCD_SDA_BIT] = two_wire_data_out;
            output_override_value[PCD_SCL_BIT] = two_wire_clock_out;
        end
    end

    // Per-pin resolution of port C
    genvar g;
    generate
        for (g = 0; g < PCD_PORTC_W; g++) begin : g_pc
            logic dir;
            assign dir = direction_override_enable[g] ? direction_override_value[g]
                                                      : portc_direction[g];
            assign portc_pin_oe[g]  = dir;
            assign portc_pin_out[g] = output_override_enable[g] ? output_override_value[g]
                                                                 : portc_data[g];
            // Register path pull-up; forced override values carry their own gating
            assign portc_pullup_on[g] = pullup_override_enable[g] ? pullup_override_value[g]
                : (portc_data[g] & ~dir & ~global_pullup_disable);
            assign portc_input_enable[g] = ~input_enable_override_enable[g]
                                           | input_enable_override_value[g];
        end
        // Port-D upper pins: compare outputs override the value only
        for (g = 0; g < PCD_PORTD_W; g++) begin : g_pd
            assign portd_pin_oe[g]    = d_direction[g];
            assign portd_pin_out[g]   = d_ovr_en[g] ? d_ovr_val[g] : portd_data[g];
            assign portd_pullup_on[g] = portd_data[g] & ~d_direction[g]
                                        & ~global_pullup_disable;
        end
    endgenerate

    assign d_direction = {portd_bit7_direction, portd_bit6_direction, portd_bit5_direction};
    assign d_ovr_en    = {timer2_compare_a_enable, timer2_compare_b_enable,
                          timer1_compare_a_enable};
    assign d_ovr_val   = {timer2_compare_a_output, timer2_compare_b_output,
                          timer1_compare_a_output};

    // Two-flop synchronisers for pad levels; a disabled input reads zero
    always_comb begin
        next_c_meta = portc_pin_in;
        next_c_sync = c_meta;
        next_d_meta = portd_pin_in;
        next_d_sync = d_meta;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            c_meta <= PCD_RST_C;
            c_sync <= PCD_RST_C;
            d_meta <= PCD_RST_D;
            d_sync <= PCD_RST_D;
        end else begin
            c_meta <= next_c_meta;
            c_sync <= next_c_sync;
            d_meta <= next_d_meta;
            d_sync <= next_d_sync;
        end
    end

    // Peripheral inputs; oscillator, test port and two-wire paths take the raw pad, not the sampled level
    assign portc_pin_sync        = c_sync & portc_input_enable;
    assign timer_osc_in_pin      = portc_pin_in[PCD_OSC_IN_BIT];
    assign timer_osc_out_active  = osc_ext;
    assign tap_data_in           = portc_pin_in[PCD_TDI_BIT];
    assign tap_mode_select       = portc_pin_in[PCD_TMS_BIT];
    assign tap_clock             = portc_pin_in[PCD_TCK_BIT];
    assign two_wire_data_in      = portc_pin_in[PCD_SDA_BIT];
    assign two_wire_clock_in     = portc_pin_in[PCD_SCL_BIT];
    assign timer1_capture_input  = d_sync[PCD_PD6_IDX];

    // Pin-change sources: group enable and mask gate each port-D synchronised level; port C passes portc_pin_sync ungated
    always_comb begin
        pin_change_source = '0;
        pin_change_source[PCD_PCS_C_LO +: PCD_PORTC_W] = portc_pin_sync;
        pin_change_source[PCD_PCS_D_LO +: PCD_PORTD_W] =
            d_sync & pin_change_mask_d & {PCD_PORTD_W{pin_change_group_enable_d}};
    end

    // Output relations
    property p_tdo_dir;
        @(posedge clk) disable iff (reset)
        test_port_enable |-> (portc_pin_oe[PCD_TDO_BIT] == tap_shift)
                             && (portc_pin_out[PCD_TDO_BIT] == tap_data_out);
    endproperty
    a_tdo_dir: assert property (p_tdo_dir) else $error("tdo pin wrong");

    property p_pullup_off;
        @(posedge clk) disable iff (reset)
        (global_pullup_disable && !test_port_enable) |-> portc_pullup_on == 8'h00;
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up not disabled");

    property p_osc;
        @(posedge clk) disable iff (reset)
        async_timer_clock_select |-> !portc_pin_oe[PCD_OSC_IN_BIT]
                                     && !portc_pullup_on[PCD_OSC_IN_BIT];
    endproperty
    a_osc: assert property (p_osc) else $error("osc pin not input");

    property p_osc7;
        @(posedge clk) disable iff (reset)
        osc_ext |-> !portc_pin_oe[PCD_OSC_OUT_BIT] && portc_input_enable[PCD_OSC_OUT_BIT];
    endproperty
    a_osc7: assert property (p_osc7) else $error("osc out pin wrong");

    property p_tw;
        @(posedge clk) disable iff (reset)
        two_wire_enable |-> portc_pin_out[PCD_SDA_BIT] == two_wire_data_out
                            && portc_pin_oe[1:0] == 2'h0 && portc_input_enable[1:0] == 2'h3;
    endproperty
    a_tw: assert property (p_tw) else $error("two-wire pins wrong");

    property p_jtag;
        @(posedge clk) disable iff (reset)
        test_port_enable |-> portc_pullup_on[5:2] == 4'hF && !portc_pin_oe[PCD_TMS_BIT];
    endproperty
    a_jtag: assert property (p_jtag) else $error("test pins wrong");

    property p_pcs_c;
        @(posedge clk) disable iff (reset)
        (pin_change_group_enable_c && pin_change_mask_c[0] && !two_wire_enable
         && !test_port_enable && !async_timer_clock_select)
        ##2 $stable(pin_change_mask_c) && $stable(pin_change_group_enable_c)
        |-> pin_change_source[PCD_PCS_C_LO] == $past(portc_pin_in[0], 2);
    endproperty
    a_pcs_c: assert property (p_pcs_c) else $error("source 16 wrong");

    property p_capt;
        @(posedge clk) disable iff (reset)
        ##2 1'b1 |-> timer1_capture_input == $past(portd_pin_in[PCD_PD6_IDX], 2);
    endproperty
    a_capt: assert property (p_capt) else $error("capture input wrong");

    property p_plain;
        @(posedge clk) disable iff (reset)
        !test_port_enable && !two_wire_enable && !async_timer_clock_select
        |-> portc_pin_oe == portc_direction && portc_pin_out == portc_data;
    endproperty
    a_plain: assert property (p_plain) else $error("registers not honoured");

endmodule : pcd_mux

// ==== verif/pcd_pad_model.sv ====
// Pad wires seen by the far side; a driven pad shows the block's value
module pcd_pad_model (
    // Block drive
    input  wire logic [7:0] c_out,
    input  wire logic [7:0] c_oe,
    input  wire logic [2:0] d_out,
    input  wire logic [2:0] d_oe,
    // Far-side drive
    input  wire logic [7:0] c_ext,
    input  wire logic [2:0] d_ext,
    // Resolved pad levels
    output logic      [7:0] c_pad,
    output logic      [2:0] d_pad
);
    timeunit 1ns;
    timeprecision 100ps;
    // Enable decides per pin who owns the wire, so no unknowns reach the pads
    assign c_pad = (c_oe & c_out) | (~c_oe & c_ext);
    assign d_pad = (d_oe & d_out) | (~d_oe & d_ext);
endmodule // pcd_pad_model

// ==== verif/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk = 0, reset = 1, gpd = 0, gc = 0, gd = 0, asel = 0, exc = 0, jt = 0;
    logic       sir = 0, sdr = 0, tdo = 0, tw = 0, twd = 0, twc = 0;
    logic       t2a = 0, t2b = 0, t1a = 0, e2a = 0, e2b = 0, e1a = 0, d7 = 0, d6 = 0, d5 = 0;
    logic [7:0] cdat = 0, cdir = 0, cext = 0, mc = 0, cpad, cout, coe, cpu, cie, csync;
    logic [2:0] ddat = 0, dext = 0, md = 0, dpad, dout, doe, dpu;
    logic       osci, osco, tdi, tms, tck, twdi, twci, cap;
    logic [31:16] pcs;
    int         fails = 0, cmp_count = 0;
    always #2 clk = ~clk;
    pcd_pad_model PAD (.c_out(cout), .c_oe(coe), .d_out(dout), .d_oe(doe), .c_ext(cext),
        .d_ext(dext), .c_pad(cpad), .d_pad(dpad));
    pcd_mux DUT (.clk(clk), .reset(reset), .portc_data(cdat), .portc_direction(cdir),
        .portc_pin_in(cpad), .portc_pin_out(cout), .portc_pin_oe(coe), .portc_pullup_on(cpu),
        .portc_input_enable(cie), .portc_pin_sync(csync), .portd_data(ddat),
        .portd_bit7_direction(d7), .portd_bit6_direction(d6), .portd_bit5_direction(d5),
        .portd_pin_in(dpad), .portd_pin_out(dout), .portd_pin_oe(doe), .portd_pullup_on(dpu),
        .global_pullup_disable(gpd), .pin_change_group_enable_c(gc),
        .pin_change_group_enable_d(gd), .pin_change_mask_c(mc), .pin_change_mask_d(md),
        .async_timer_clock_select(asel), .external_clock_select(exc), .timer_osc_in_pin(osci),
        .timer_osc_out_active(osco), .test_port_enable(jt), .tap_shift_instruction_state(sir),
        .tap_shift_data_state(sdr), .tap_data_out(tdo), .tap_data_in(tdi),
        .tap_mode_select(tms), .tap_clock(tck), .two_wire_enable(tw), .two_wire_data_out(twd),
        .two_wire_clock_out(twc), .two_wire_data_in(twdi), .two_wire_clock_in(twci),
        .timer2_compare_a_output(t2a), .timer2_compare_b_output(t2b),
        .timer1_compare_a_output(t1a), .timer2_compare_a_enable(e2a),
        .timer2_compare_b_enable(e2b), .timer1_compare_a_enable(e1a),
        .timer1_capture_input(cap), .pin_change_source(pcs));
    // Compare one value with its expectation
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Let inputs set at one falling edge settle until the next
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic print_verdict();
        if (fails == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard, far beyond the few dozen cycles the sequence needs
    initial begin
        #20000;
        fails++;
        print_verdict();
    end
    initial begin
        tick(3);
        reset = 0;
        // Plain port path: inputs with data high get pull-ups
        cdat = 8'hF0; cdir = 8'h0F; ddat = 3'h7; tick(1);
        chk(coe, 8'h0F);
        chk(cout, 8'hF0);
        chk(cpu, 8'hF0);
        chk(dpu, 3'h7);
        chk(dout, 3'h7);
        gpd = 1; tick(1);
        chk({dpu, cpu}, 11'h000);
        // Pin-change routing first, then two-wire active with inputs still live
        cdir = 8'h00; cdat = 8'h03; gc = 1; mc = 8'hFF; gd = 1; md = 3'h7;
        cext = 8'hA5; dext = 3'h2; tick(3);
        chk(pcs, 16'h40A5);
        chk(csync, 8'hA5);
        chk(cap, 1'b1);
        tw = 1; twd = 1; twc = 0; tick(1);
        chk(cie, 8'hFF);
        chk({twdi, twci}, 2'b01);
        chk(pcs[23:16], 8'hA5);
        chk(cout[1:0], 2'b10);
        chk(coe, 8'h00);
        chk(cpu[1:0], 2'b00);
        md = 3'h0; dext = 3'h0; gpd = 0; cdir = 8'h03; tick(3);
        chk(pcs[31:29], 3'h0);
        chk(cap, 1'b0);
        chk({coe[1:0], cpu[1:0]}, 4'h3);
        // Timer oscillator takes the two upper pins, bit 7 only with external clock select
        tw = 0; gc = 0; mc = 8'h00; cdir = 8'hC0; cdat = 8'hC0; asel = 1; exc = 1;
        cext = 8'h40; tick(1);
        chk({coe[7:6], cpu[7:6], cie[7:6]}, 6'b000011);
        chk({osco, osci}, 2'b11);
        exc = 0; cext = 8'h00; tick(1);
        chk({osco, osci, coe[7:6], cpu[6], cie[6]}, 6'b001001);
        // Test port: pull-ups on, inputs, bit 4 drives only while shifting
        asel = 0; cdat = 8'h00; cdir = 8'h3C; jt = 1; tdo = 1; cext = 8'h24; tick(1);
        chk({coe[5:2], cpu[5:2], cie[5:2]}, 12'h0FF);
        chk({tdi, tms, tck}, 3'b101);
        chk(cout[4], 1'b1);
        for (int i = 1; i < 4; i++) begin
            {sir, sdr} = i[1:0]; tick(1);
            chk(coe[5:2], 4'h4);
        end
        sir = 0; sdr = 0; tdo = 0; tick(1);
        chk({coe[4], cout[4]}, 2'b00);
        // Compare outputs appear once direction is set first
        jt = 0; d7 = 1; d6 = 1; d5 = 1; tick(1);
        e2a = 1; e2b = 1; e1a = 1; t2a = 1; t2b = 0; t1a = 1; tick(1);
        chk({doe, dout}, 6'o75);
        t2a = 0; t2b = 1; t1a = 0; tick(3);
        chk({dout, cap}, 4'b0101);
        print_verdict();
    end
endmodule // testbench
